// file: verilog/umh_pkg.sv
// Purpose: shared constants for the modem handshake block
// Assumes: classic wishbone slave, 32-bit data, one clock
// Notes: offsets are byte addresses of aligned words
package umh_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NPORT = 2;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STATUS0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONTROL0 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ENABLE0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IDENT0 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CONTROL1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ENABLE1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IDENT1 = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_EVT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h10;
  // modem status fields
  localparam int unsigned MS_DCTS = 0;
  localparam int unsigned MS_DDSR = 1;
  localparam int unsigned MS_TERI = 2;
  localparam int unsigned MS_DDCD = 3;
  localparam int unsigned MS_CTS = 4;
  localparam int unsigned MS_DSR = 5;
  localparam int unsigned MS_RING = 6;
  localparam int unsigned MS_CARRIER = 7;
  // modem control fields
  localparam int unsigned MC_TERM = 0;
  localparam int unsigned MC_RTS = 1;
  localparam int unsigned MC_AUX2 = 3;
  localparam int unsigned MC_LOOP = 4;
  localparam int unsigned MC_W = 5;
  localparam logic [MC_W-1:0] MC_RESET = 5'h00;
  // interrupt enable fields
  localparam int unsigned IE_MODEM = 3;
  localparam logic [3:0] IE_RESET = 4'h0;
  // interrupt identification
  localparam logic [2:0] ID_MODEM = 3'h0;
  localparam logic [2:0] ID_NONE = 3'h1;
  localparam logic [NPORT-1:0] EVT_RESET = 2'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : umh_pkg

// file: verilog/umh_sync.sv
// Purpose: two flip-flop reset release
// Assumes: async active-low input reset
// Notes: output deasserts two edges after release
`timescale 1ns/1ns
module umh_sync (
  input wire logic i_mclk,
  input wire logic i_rstn,
  output logic o_rstn
);
  logic stage;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage <= 1'b0;
      o_rstn <= 1'b0;
    end else begin
      stage <= 1'b1;
      o_rstn <= stage;
    end
  end
endmodule : umh_sync

// file: verilog/umh_port.sv
// Purpose: modem handshake state of one serial port
// Assumes: inputs synchronous, clear-on-read strobe from bus
// Notes: change flags set on rising input, set beats clear
`timescale 1ns/1ns
module umh_port (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_active,
  input wire logic [3:0] i_modem_n,
  input wire logic i_status_rd,
  input wire logic [umh_pkg::MC_W-1:0] i_control,
  input wire logic [3:0] i_enable,
  output logic [7:0] o_status,
  output logic o_change,
  output logic o_irq,
  output logic o_rts_n,
  output logic o_term_ready_n
);
  import umh_pkg::*;

  logic [3:0] prev_n;
  logic [3:0] delta;
  logic [3:0] rise;
  logic [3:0] next_delta;

  // index order: 0 cts, 1 dsr, 2 bell, 3 carrier
  always_comb begin
    rise = i_modem_n & ~prev_n;
    next_delta = delta;
    if (i_status_rd) begin
      next_delta = 4'h0;
    end
    if (i_active) begin
      next_delta = next_delta | rise;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_n <= 4'hf;
      delta <= 4'h0;
    end else if (i_ce) begin
      if (i_active) begin
        prev_n <= i_modem_n;
      end
      delta <= next_delta;
    end
  end

  always_comb begin
    o_status = 8'h00;
    o_status[MS_DCTS] = delta[0];
    o_status[MS_DDSR] = delta[1];
    o_status[MS_TERI] = delta[2];
    o_status[MS_DDCD] = delta[3];
    o_status[MS_CTS] = ~prev_n[0];
    o_status[MS_DSR] = ~prev_n[1];
    o_status[MS_RING] = ~prev_n[2];
    o_status[MS_CARRIER] = ~prev_n[3];
  end

  // any state change of an input, for the event register
  assign o_change = i_active && (prev_n != i_modem_n);
  assign o_irq = i_enable[IE_MODEM] && (delta != 4'h0);
  assign o_rts_n = ~(i_control[MC_RTS] & ~i_control[MC_LOOP]);
  assign o_term_ready_n = ~(i_control[MC_TERM] & ~i_control[MC_LOOP]);
endmodule : umh_port

// file: verilog/umh_top.sv
// Purpose: modem handshake logic for two serial ports
// Assumes: classic wishbone slave on i_mclk, synchronous modem inputs
// Notes: tri-state pins appear as output plus output enable
`timescale 1ns/1ns

module umh_top (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_supply_valid_in,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [umh_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [umh_pkg::DATA_W-1:0] i_wb_dat,
  output logic [umh_pkg::DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [umh_pkg::NPORT-1:0] i_clear_to_send_in_n,
  input wire logic [umh_pkg::NPORT-1:0] i_data_set_ready_in_n,
  input wire logic [umh_pkg::NPORT-1:0] i_carrier_detect_in_n,
  input wire logic [umh_pkg::NPORT-1:0] i_bell_detect_in_n,
  output logic [umh_pkg::NPORT-1:0] o_rts_n,
  output logic [umh_pkg::NPORT-1:0] o_rts_oe,
  output logic [umh_pkg::NPORT-1:0] o_term_ready_n,
  output logic [umh_pkg::NPORT-1:0] o_term_ready_oe,
  output logic [umh_pkg::NPORT-1:0] o_port_irq,
  output logic [umh_pkg::NPORT-1:0] o_port_irq_oe,
  output logic o_irq
);
  import umh_pkg::*;

  logic rstn;
  logic req;
  logic ack;
  logic wr;
  logic rd;
  logic [NPORT-1:0] sel_port;
  logic [ADDR_W-1:0] local_adr;
  logic [7:0] status [NPORT];
  logic [MC_W-1:0] control [NPORT];
  logic [3:0] enable [NPORT];
  logic [NPORT-1:0] status_rd;
  logic [NPORT-1:0] change;
  logic [NPORT-1:0] port_int;
  logic [NPORT-1:0] evt;
  logic [NPORT-1:0] mask;
  logic [NPORT-1:0] next_evt;
  logic [NPORT-1:0] rts_n;
  logic [NPORT-1:0] term_n;
  logic [DATA_W-1:0] next_dat;

  umh_sync u_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .o_rstn(rstn)
  );

  // bus ignored entirely while supply is not valid
  assign req = i_wb_cyc && i_wb_stb && i_supply_valid_in && i_ce && !ack;
  assign wr = req && i_wb_we;
  assign rd = req && !i_wb_we;
  assign o_wb_ack = ack;

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else if (i_ce) begin
      ack <= req;
    end
  end

  always_comb begin
    sel_port = '0;
    local_adr = i_wb_adr;
    if (i_wb_adr < PORT_STRIDE) begin
      sel_port[0] = 1'b1;
    end else if (i_wb_adr < OFF_EVT) begin
      sel_port[1] = 1'b1;
      local_adr = i_wb_adr - PORT_STRIDE;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      // inputs disabled while supply is not valid; state is kept
      umh_port u_port (
        .i_mclk(i_mclk),
        .i_rstn(rstn),
        .i_ce(i_ce),
        .i_active(i_supply_valid_in),
        .i_modem_n({i_carrier_detect_in_n[gp], i_bell_detect_in_n[gp],
                    i_data_set_ready_in_n[gp], i_clear_to_send_in_n[gp]}),
        .i_status_rd(status_rd[gp]),
        .i_control(control[gp]),
        .i_enable(enable[gp]),
        .o_status(status[gp]),
        .o_change(change[gp]),
        .o_irq(port_int[gp]),
        .o_rts_n(rts_n[gp]),
        .o_term_ready_n(term_n[gp])
      );

      // reading status clears change flags
      assign status_rd[gp] = rd && sel_port[gp] && (local_adr == OFF_STATUS0)
                             && i_wb_sel[0];

      always_ff @(posedge i_mclk or negedge rstn) begin
        if (!rstn) begin
          control[gp] <= MC_RESET;
          enable[gp] <= IE_RESET;
        end else if (i_ce && wr && sel_port[gp] && i_wb_sel[0]) begin
          if (local_adr == OFF_CONTROL0) begin
            control[gp] <= i_wb_dat[MC_W-1:0];
          end
          if (local_adr == OFF_ENABLE0) begin
            enable[gp] <= i_wb_dat[3:0];
          end
        end
      end

      // handshake outputs float while supply is not valid
      assign o_rts_n[gp] = rts_n[gp];
      assign o_term_ready_n[gp] = term_n[gp];
      assign o_rts_oe[gp] = i_supply_valid_in;
      assign o_term_ready_oe[gp] = i_supply_valid_in;
      // request line driven high only when aux out two is set
      assign o_port_irq[gp] = port_int[gp];
      assign o_port_irq_oe[gp] = control[gp][MC_AUX2] && i_supply_valid_in;
    end
  endgenerate

  // sticky events: set wins over write-one clear
  always_comb begin
    next_evt = evt;
    if (wr && i_wb_adr == OFF_EVT && i_wb_sel[0]) begin
      next_evt = next_evt & ~i_wb_dat[NPORT-1:0];
    end
    next_evt = next_evt | change;
  end

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      evt <= EVT_RESET;
      mask <= EVT_RESET;
    end else if (i_ce) begin
      evt <= next_evt;
      if (wr && i_wb_adr == OFF_MASK && i_wb_sel[0]) begin
        mask <= i_wb_dat[NPORT-1:0];
      end
    end
  end

  assign o_irq = |(evt & mask);

  // modem change is the only source here, so it reports code 000
  function automatic logic [2:0] ident(input logic pend);
    ident = pend ? ID_MODEM : ID_NONE;
  endfunction : ident

  always_comb begin
    next_dat = UNMAPPED_DATA;
    if (i_wb_adr == OFF_EVT) begin
      next_dat[NPORT-1:0] = evt;
    end else if (i_wb_adr == OFF_MASK) begin
      next_dat[NPORT-1:0] = mask;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (sel_port[p]) begin
          if (local_adr == OFF_STATUS0) begin
            next_dat[7:0] = status[p];
          end else if (local_adr == OFF_CONTROL0) begin
            next_dat[MC_W-1:0] = control[p];
          end else if (local_adr == OFF_ENABLE0) begin
            next_dat[3:0] = enable[p];
          end else if (local_adr == OFF_IDENT0) begin
            next_dat[2:0] = ident(port_int[p]);
          end
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      o_wb_dat <= UNMAPPED_DATA;
    end else if (i_ce && rd) begin
      o_wb_dat <= next_dat;
    end
  end

  // cts only feeds status and interrupt; nothing here gates a transmitter

  chk_ack_one: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && req) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single cycle after request");

  chk_cts_status: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && !status_rd[0]) |=>
      status[0][MS_CTS] == !$past(i_clear_to_send_in_n[0]))
    else $error("cts status not complement of input");

  chk_cts_delta: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && i_clear_to_send_in_n[0] && status[0][MS_CTS])
      |=> status[0][MS_DCTS])
    else $error("cts rise did not set change bit");

  chk_dsr_delta: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && i_data_set_ready_in_n[1] && status[1][MS_DSR])
      |=> status[1][MS_DDSR])
    else $error("dsr rise did not set change bit");

  chk_carrier_delta: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && i_carrier_detect_in_n[0] && status[0][MS_CARRIER])
      |=> status[0][MS_DDCD])
    else $error("carrier rise did not set change bit");

  chk_bell_delta: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && i_bell_detect_in_n[0] && status[0][MS_RING])
      |=> status[0][MS_TERI])
    else $error("bell rise did not set change bit");

  chk_int_enable: assert property (@(posedge i_mclk) disable iff (!rstn)
    port_int[0] == (enable[0][IE_MODEM] && (status[0][3:0] != 4'h0)))
    else $error("modem interrupt not tied to enable and flags");

  chk_loop_idle: assert property (@(posedge i_mclk) disable iff (!rstn)
    control[0][MC_LOOP] |-> (o_rts_n[0] && o_term_ready_n[0]))
    else $error("handshake output active in loopback");

  chk_rts_drive: assert property (@(posedge i_mclk) disable iff (!rstn)
    (!control[1][MC_LOOP] && control[1][MC_RTS]) |-> !o_rts_n[1])
    else $error("rts not asserted from control bit");

  chk_term_drive: assert property (@(posedge i_mclk) disable iff (!rstn)
    (!control[0][MC_LOOP] && !control[0][MC_TERM]) |-> o_term_ready_n[0])
    else $error("terminal ready asserted without control bit");

  chk_read_clear: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && status_rd[0] && (({i_carrier_detect_in_n[0], i_bell_detect_in_n[0],
      i_data_set_ready_in_n[0], i_clear_to_send_in_n[0]} & status[0][7:4]) == 4'h0))
      |=> status[0][3:0] == 4'h0)
    else $error("status read did not clear change flags");

  chk_irq_gate: assert property (@(posedge i_mclk) disable iff (!rstn)
    !control[1][MC_AUX2] |-> !o_port_irq_oe[1])
    else $error("request line driven with aux out two low");

  chk_supply_hold: assert property (@(posedge i_mclk) disable iff (!rstn)
    !i_supply_valid_in |=> $stable(control[0]) && $stable(status[0][7:4]))
    else $error("state changed while supply invalid");

  chk_cts_free: assert property (@(posedge i_mclk) disable iff (!rstn)
    ($changed(i_clear_to_send_in_n[0]) && $stable(control[0])) |-> $stable(o_rts_n[0]))
    else $error("cts change moved request-to-send");

  chk_cts_status1: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in) |=>
      status[1][MS_CTS] == !$past(i_clear_to_send_in_n[1]))
    else $error("port1 cts status not complement of input");

  chk_dsr_status: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in) |=>
      status[0][MS_DSR] == !$past(i_data_set_ready_in_n[0]))
    else $error("dsr status not complement of input");

  chk_carrier_status: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in) |=>
      status[1][MS_CARRIER] == !$past(i_carrier_detect_in_n[1]))
    else $error("carrier status not complement of input");

  chk_bell_status: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in) |=>
      status[1][MS_RING] == !$past(i_bell_detect_in_n[1]))
    else $error("bell status not complement of input");

  chk_int_port1: assert property (@(posedge i_mclk) disable iff (!rstn)
    port_int[1] == (enable[1][IE_MODEM] && (status[1][3:0] != 4'h0)))
    else $error("port1 interrupt not tied to enable and flags");

  chk_int_rise: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && !wr && enable[0][IE_MODEM] &&
     i_clear_to_send_in_n[0] && status[0][MS_CTS]) |=> o_port_irq[0])
    else $error("enabled cts change raised no port interrupt");

  chk_reset_idle: assert property (@(posedge i_mclk)
    !rstn |-> (o_rts_n == '1 && o_term_ready_n == '1))
    else $error("handshake output active during reset");

  chk_loop_idle1: assert property (@(posedge i_mclk) disable iff (!rstn)
    control[1][MC_LOOP] |-> (o_rts_n[1] && o_term_ready_n[1]))
    else $error("port1 handshake output active in loopback");

  chk_term_drive1: assert property (@(posedge i_mclk) disable iff (!rstn)
    (!control[1][MC_LOOP] && control[1][MC_TERM]) |-> !o_term_ready_n[1])
    else $error("terminal ready not asserted from control bit");

  chk_rts_off: assert property (@(posedge i_mclk) disable iff (!rstn)
    !control[0][MC_RTS] |-> o_rts_n[0])
    else $error("rts asserted without control bit");

  chk_float_out: assert property (@(posedge i_mclk) disable iff (!rstn)
    !i_supply_valid_in |-> (o_rts_oe == '0 && o_term_ready_oe == '0 && o_port_irq_oe == '0))
    else $error("output driven while supply invalid");

  chk_bus_ignore: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && !i_supply_valid_in) |=> !o_wb_ack)
    else $error("bus answered while supply invalid");

  chk_irq_change: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && i_supply_valid_in && !wr && mask[0] &&
     (i_clear_to_send_in_n[0] == status[0][MS_CTS])) |=> o_irq)
    else $error("unmasked cts change raised no interrupt");

  chk_code_modem: assert property (@(posedge i_mclk) disable iff (!rstn)
    (rd && sel_port[0] && (local_adr == OFF_IDENT0) && port_int[0])
      |=> o_wb_dat[2:0] == ID_MODEM)
    else $error("pending modem interrupt not reported as 000");

  chk_code_none: assert property (@(posedge i_mclk) disable iff (!rstn)
    (rd && sel_port[0] && (local_adr == OFF_IDENT0) && !port_int[0])
      |=> o_wb_dat[2:0] == ID_NONE)
    else $error("idle port not reported as no interrupt");

  chk_clear_port1: assert property (@(posedge i_mclk) disable iff (!rstn)
    (i_ce && status_rd[1] && (({i_carrier_detect_in_n[1], i_bell_detect_in_n[1],
      i_data_set_ready_in_n[1], i_clear_to_send_in_n[1]} & status[1][7:4]) == 4'h0))
      |=> status[1][3:0] == 4'h0)
    else $error("port1 status read did not clear change flags");

  chk_evt_sticky: assert property (@(posedge i_mclk) disable iff (!rstn)
    (evt[1] && !(wr && (i_wb_adr == OFF_EVT))) |=> evt[1])
    else $error("event bit lost without a clear");
endmodule : umh_top

// file: dv/umh_modem_model.sv
// Purpose: behavioural modem driving the four handshake inputs of both ports
// Assumes: bench sets the wanted levels, model launches them after a clock edge
// Notes: bit order per input is port0 then port1; lines idle high (inactive)
`timescale 1ns/1ns
module umh_modem_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_want_n,
  output logic [umh_pkg::NPORT-1:0] o_cts_n,
  output logic [umh_pkg::NPORT-1:0] o_dsr_n,
  output logic [umh_pkg::NPORT-1:0] o_bell_n,
  output logic [umh_pkg::NPORT-1:0] o_carrier_n
);
  logic [7:0] line_n = 8'hff;
  // lines change only just after an edge, like a synchronous source
  always @(posedge i_mclk) begin
    line_n <= i_want_n;
  end
  assign o_cts_n = line_n[1:0];
  assign o_dsr_n = line_n[3:2];
  assign o_bell_n = line_n[5:4];
  assign o_carrier_n = line_n[7:6];
endmodule : umh_modem_model

// file: dv/umh_top_tb.sv
// Purpose: self-checking bench for the two-port modem handshake block
// Assumes: classic wishbone master, modem model on the handshake inputs
// Notes: each scenario is a task that judges its own results
`timescale 1ns/1ns
module umh_top_tb;
  import umh_pkg::*;
  logic mclk, rstn, ce, supply, cyc, stb, we;
  logic [ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [DATA_W-1:0] wdat, rdat;
  logic ack, irq;
  logic [NPORT-1:0] cts_n, dsr_n, car_n, bell_n, rts_n, rts_oe, trm_n, trm_oe, pirq, pirq_oe;
  logic [7:0] want_n;
  int num_errors = 0;
  int n_compared = 0;

  umh_modem_model u_modem (.i_mclk(mclk), .i_want_n(want_n), .o_cts_n(cts_n),
    .o_dsr_n(dsr_n), .o_bell_n(bell_n), .o_carrier_n(car_n));

  umh_top dut (.i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_supply_valid_in(supply),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_clear_to_send_in_n(cts_n),
    .i_data_set_ready_in_n(dsr_n), .i_carrier_detect_in_n(car_n),
    .i_bell_detect_in_n(bell_n), .o_rts_n(rts_n), .o_rts_oe(rts_oe),
    .o_term_ready_n(trm_n), .o_term_ready_oe(trm_oe), .o_port_irq(pirq),
    .o_port_irq_oe(pirq_oe), .o_irq(irq));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic conclude();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  // one classic cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) begin
      @(posedge mclk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
    check(32'(ack), 32'h0);
  endtask : wb

  // write that must be refused: no ack while held, then withdrawn
  task automatic wr_refused(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= a;
    wdat <= d;
    repeat (4) begin
      @(posedge mclk);
      check(32'(ack), 32'h0);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wr_refused

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic set_line(input int p, input int k, input logic v);
    want_n[k * 2 + p] <= v;
    repeat (3) @(posedge mclk);
  endtask : set_line

  task automatic t_reset();
    check(32'(rts_n), 32'h3);
    check(32'(trm_n), 32'h3);
    rd(OFF_STATUS0, 32'h0);
    rd(8'h3c, 32'h0);
  endtask : t_reset

  task automatic t_control();
    wr(OFF_CONTROL0, 32'h2);
    check(32'(rts_n), 32'h2);
    check(32'(trm_n), 32'h3);
    set_line(0, 0, 1'b0);
    check(32'(rts_n), 32'h2);
    set_line(0, 0, 1'b1);
    check(32'(rts_n), 32'h2);
    wr(OFF_CONTROL1, 32'h1);
    check(32'(trm_n), 32'h1);
    rd(OFF_CONTROL1, 32'h1);
    wr(OFF_CONTROL0, 32'h13);
    check(32'(rts_n), 32'h3);
    check(32'(trm_n), 32'h1);
    // reset in mid-run with both outputs driven low
    wr(OFF_CONTROL0, 32'h3);
    check(32'(trm_n), 32'h0);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    check(32'(rts_n), 32'h3);
    check(32'(trm_n), 32'h3);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : t_control

  task automatic t_modem();
    logic [ADDR_W-1:0] sa;
    for (int p = 0; p < 2; p++) begin
      sa = (p == 1) ? OFF_STATUS1 : OFF_STATUS0;
      for (int k = 0; k < 4; k++) begin
        set_line(p, k, 1'b0);
        rd(sa, 32'h1 << (k + 4));
        set_line(p, k, 1'b1);
        rd(sa, 32'h1 << k);
        rd(sa, 32'h0);
      end
    end
  endtask : t_modem

  task automatic t_irq();
    wr(OFF_EVT, 32'h3);
    wr(OFF_ENABLE0, 32'h8);
    wr(OFF_CONTROL0, 32'h8);
    wr(OFF_MASK, 32'h1);
    check(32'(pirq_oe), 32'h1);
    check(32'(irq), 32'h0);
    set_line(0, 0, 1'b0);
    check(32'(pirq), 32'h0);
    check(32'(irq), 32'h1);
    rd(OFF_IDENT0, 32'h1);
    set_line(0, 0, 1'b1);
    check(32'(pirq), 32'h1);
    rd(OFF_IDENT0, 32'h0);
    rd(OFF_STATUS0, 32'h1);
    check(32'(pirq), 32'h0);
    rd(OFF_IDENT0, 32'h1);
    wr(OFF_EVT, 32'h1);
    check(32'(irq), 32'h0);
    wr(OFF_MASK, 32'h0);
    set_line(0, 1, 1'b0);
    check(32'(irq), 32'h0);
    rd(OFF_EVT, 32'h1);
    set_line(0, 1, 1'b1);
    rd(OFF_STATUS0, 32'h2);
    wr(OFF_EVT, 32'h1);
    wr(OFF_CONTROL0, 32'h0);
    check(32'(pirq_oe), 32'h0);
  endtask : t_irq

  // clock enable low: a pulse on an input must leave no trace
  task automatic t_enable();
    ce <= 1'b0;
    set_line(1, 2, 1'b0);
    set_line(1, 2, 1'b1);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(OFF_STATUS1, 32'h0);
    rd(OFF_EVT, 32'h0);
  endtask : t_enable

  task automatic t_supply();
    wr(OFF_CONTROL0, 32'h2);
    supply <= 1'b0;
    repeat (2) @(posedge mclk);
    check(32'({rts_oe, trm_oe, pirq_oe}), 32'h0);
    wr_refused(OFF_CONTROL0, 32'h0);
    set_line(1, 3, 1'b0);
    set_line(1, 3, 1'b1);
    supply <= 1'b1;
    repeat (3) @(posedge mclk);
    check(32'(rts_oe), 32'h3);
    check(32'(rts_n), 32'h2);
    rd(OFF_STATUS1, 32'h0);
    rd(OFF_CONTROL0, 32'h2);
  endtask : t_supply

  initial begin
    #(50 * 4000);
    num_errors++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    supply = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hf;
    wdat = '0;
    want_n = 8'hff;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_control();
    t_modem();
    t_irq();
    t_enable();
    t_supply();
    conclude();
  end
endmodule : umh_top_tb
